/* verilog/fscd_top.sv */
// Serial flash setting-command decoder with APB view of its state
//
// Local design decisions: the APB register port and the placing of the registers.
`timescale 1ns/100ps
`include "fscd_defines.svh"
// What this block does
// R1: Opcode 06 sets write permission latch.
// R2: Opcode 04 clears write permission latch.
// R3: Opcode 05 returns status byte.
// R4: Opcode 15 returns configuration byte.
// R5: Opcode 01 loads status, then configuration.
// R6: Opcode 68 selects individual block protection.
// R7: Opcode 35 enters four-lane mode from single.
// R8: Opcode F5 leaves four-lane mode only there.
// R9: Opcode B7 sets long address flag.
// R10: Opcode E9 clears long address flag.
// R11: B0 suspends, 30 resumes program/erase.
// R12: Opcode AB wakes device from sleep.
// R13: Status write ignored without write latch.
module fscd_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        sclk,
  input  wire logic        cs_n,
  input  wire logic [3:0]  io_i,
  output logic [3:0]       io_o,
  output logic [3:0]       io_oe_n
);

  // Synchroniser chains; stage 0 feeds stage 1 only
  logic [2:0]             sclk_q;   // Link clock, stage 2 for edges
  logic [2:0]             csn_q;    // Chip select, stage 2 for edges
  logic [3:0]             io_m_q;   // Data, first stage
  logic [3:0]             io_s_q;   // Data, usable
  // Frame decoding
  logic                   act;      // Frame open
  logic                   rise;     // Link clock rising
  logic                   fall;     // Link clock falling
  logic                   cs_end;   // Frame just closed
  logic [2:0]             last;     // Last edge of a byte
  logic [2:0]             bit_q;    // Edge count in byte
  logic [1:0]             byte_q;   // Byte count, saturating
  logic [7:0]             rx_q;     // Incoming shift register
  logic [7:0]             op;       // Byte completing now
  logic                   done;     // Byte completes now
  logic                   go;       // Opcode taken now
  logic [7:0]             cmd_q;    // Last opcode taken
  // Mode state
  fscd_pkg::fscd_lane_t   lane_q;   // Command lane width
  logic                   four;     // Four-lane shorthand
  logic                   wl_q;     // Write permission latch
  logic                   long_q;   // Long address flag
  logic                   prot_q;   // Individual block protection
  logic                   busy_q;   // Program/erase running
  logic                   susp_q;   // Program/erase suspended
  logic                   sleep_q;  // Deep power-down
  logic                   slp_set;  // Software sleep request
  // Status/configuration write path
  logic                   arm_q;    // Write opcode seen this frame
  logic [1:0]             wcnt_q;   // Data bytes captured
  logic [15:0]            wbuf_q;   // Captured data bytes
  logic                   commit;   // Write takes effect now
  logic [7:0]             sr_q;     // Stored status byte
  logic [7:0]             cr_q;     // Configuration byte
  logic [7:0]             stat;     // Status byte as seen
  // Read-back path
  fscd_pkg::fscd_src_t    src_q;    // What is being returned
  logic [7:0]             tx_q;     // Outgoing shift register
  logic [2:0]             obit_q;   // Edge count of outgoing byte
  logic [7:0]             rd_val;   // Fresh byte for reload
  // APB
  logic                   rdy_q;    // Answer prepared
  logic                   wr;       // Write completes now
  logic [31:0]            rd;       // Read mux
  logic                   err;      // Unmapped address

  // Synchronisers; logic reads stages 1 and 2 of clock and select, and the second data stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_q <= 3'h0;
      csn_q  <= 3'h7;
      io_m_q <= 4'h0;
      io_s_q <= 4'h0;
    end else if (ce) begin
      sclk_q <= {sclk_q[1:0], sclk};
      csn_q  <= {csn_q[1:0], cs_n};
      io_m_q <= io_i;
      io_s_q <= io_m_q;
    end
  end

  // Edge and frame decode
  assign act    = ~csn_q[1];
  assign rise   = sclk_q[1] & ~sclk_q[2];
  assign fall   = ~sclk_q[1] & sclk_q[2];
  assign cs_end = csn_q[1] & ~csn_q[2];
  assign four   = (lane_q == fscd_pkg::FSCD_LANE_FOUR);
  assign last   = four ? `FSCD_LAST_FOUR : `FSCD_LAST_ONE;
  // Four-lane takes a nibble per edge, single lane takes io0
  assign op     = four ? {rx_q[3:0], io_s_q} : {rx_q[6:0], io_s_q[0]};
  assign done   = act & rise & (bit_q == last);
  // Asleep, only the wake opcode is heard
  assign go     = done & (byte_q == 2'h0) & (!sleep_q | op == `FSCD_OP_WAKE);

  // Bit and byte counters, cleared between frames
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bit_q  <= 3'h0;
      byte_q <= 2'h0;
      rx_q   <= 8'h00;
    end else if (ce) begin
      if (!act) begin
        bit_q  <= 3'h0;
        byte_q <= 2'h0;
      end else if (rise) begin
        rx_q  <= op;
        bit_q <= (bit_q == last) ? 3'h0 : bit_q + 3'h1;
        // Saturate: only the first data bytes matter
        if (bit_q == last && byte_q != 2'h3) begin
          byte_q <= byte_q + 2'h1;
        end
      end
    end
  end

  // Last opcode, kept for software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_q <= 8'h00;
    end else if (ce && go) begin
      cmd_q <= op;
    end
  end

  // Write permission latch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wl_q <= 1'b0;
    end else if (ce) begin
      if (go && op == `FSCD_OP_WL_SET) begin
        wl_q <= 1'b1; // see R1
      end else if (go && op == `FSCD_OP_WL_CLR) begin
        wl_q <= 1'b0; // see R2
      end else if (commit) begin
        wl_q <= 1'b0; // One write per enable
      end
    end
  end
  wl_set_a: assert property (@(posedge pclk) disable iff (!presetn) // see R1
    ce && go && op == `FSCD_OP_WL_SET |=> wl_q) else $error("latch not set");
  wl_clr_a: assert property (@(posedge pclk) disable iff (!presetn) // see R2
    ce && go && op == `FSCD_OP_WL_CLR |=> !wl_q) else $error("latch not cleared");

  // Lane mode; each switch only from the opposite mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lane_q <= fscd_pkg::FSCD_LANE_ONE;
    end else if (ce && go) begin
      case (op)
        `FSCD_OP_FOUR_IN: begin
          if (!four) lane_q <= fscd_pkg::FSCD_LANE_FOUR; // see R7
        end
        `FSCD_OP_FOUR_OUT: begin
          if (four) lane_q <= fscd_pkg::FSCD_LANE_ONE; // see R8
        end
        default: ;
      endcase
    end
  end
  lane_in_a: assert property (@(posedge pclk) disable iff (!presetn) // see R7
    ce && go && op == `FSCD_OP_FOUR_IN && !four |=> four) else $error("no four-lane");
  lane_out_a: assert property (@(posedge pclk) disable iff (!presetn) // see R8
    ce && go && op == `FSCD_OP_FOUR_OUT |=> !four) else $error("still four-lane");

  // Address length and protection scheme
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      long_q <= 1'b0;
      prot_q <= 1'b0;
    end else if (ce && go) begin
      case (op)
        `FSCD_OP_LONG_IN:  long_q <= 1'b1; // see R9
        `FSCD_OP_LONG_OUT: long_q <= 1'b0; // see R10
        `FSCD_OP_PROT_SEL: prot_q <= 1'b1; // see R6
        default: ;
      endcase
    end
  end
  long_in_a: assert property (@(posedge pclk) disable iff (!presetn) // see R9
    ce && go && op == `FSCD_OP_LONG_IN |=> long_q) else $error("long flag not set");
  long_out_a: assert property (@(posedge pclk) disable iff (!presetn) // see R10
    ce && go && op == `FSCD_OP_LONG_OUT |=> !long_q) else $error("long flag stuck");
  prot_sel_a: assert property (@(posedge pclk) disable iff (!presetn) // see R6
    ce && go && op == `FSCD_OP_PROT_SEL |=> prot_q) else $error("protection not set");

  // Suspend only has meaning while an operation runs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      susp_q <= 1'b0;
    end else if (ce) begin
      if (go && op == `FSCD_OP_SUSP && busy_q) begin
        susp_q <= 1'b1; // see R11
      end else if ((go && op == `FSCD_OP_RESUME) || !busy_q) begin
        susp_q <= 1'b0; // see R11
      end
    end
  end
  pe_susp_a: assert property (@(posedge pclk) disable iff (!presetn) // see R11
    ce && go && op == `FSCD_OP_SUSP && busy_q |=> susp_q ##1 susp_q || !busy_q)
    else $error("suspend lost");

  // Sleep: software request wins over a wake in the same cycle
  assign slp_set = wr & (paddr == `FSCD_A_CTRL) & pwdata[`FSCD_CTRL_SLEEP];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleep_q <= 1'b0;
    end else if (ce) begin
      if (slp_set) begin
        sleep_q <= 1'b1;
      end else if (go && op == `FSCD_OP_WAKE) begin
        sleep_q <= 1'b0; // see R12
      end
    end
  end
  wake_a: assert property (@(posedge pclk) disable iff (!presetn) // see R12
    ce && go && op == `FSCD_OP_WAKE && !slp_set |=> !sleep_q) else $error("no wake");

  // Capture up to two data bytes after a write opcode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      arm_q  <= 1'b0;
      wcnt_q <= 2'h0;
      wbuf_q <= 16'h0000;
    end else if (ce) begin
      if (!act) begin
        arm_q  <= 1'b0;
        wcnt_q <= 2'h0;
      end else if (go) begin
        arm_q  <= (op == `FSCD_OP_SC_WR);
        wcnt_q <= 2'h0;
      end else if (done && arm_q && wcnt_q != `FSCD_WR_MAX) begin
        // First byte to status lane, second to configuration lane
        if (wcnt_q == 2'h0) wbuf_q[`FSCD_RG_SR] <= op; // see R5
        else wbuf_q[`FSCD_RG_CR] <= op; // see R5
        wcnt_q <= wcnt_q + 2'h1;
      end
    end
  end

  // Write lands when the frame closes, and only with the latch set
  assign commit = cs_end & arm_q & (wcnt_q != 2'h0) & wl_q; // see R13
  sr_gate_a: assert property (@(posedge pclk) disable iff (!presetn) // see R13
    ce && cs_end && arm_q && !wl_q |=> $stable(sr_q) && $stable(cr_q))
    else $error("write without latch");

  // Status and configuration storage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sr_q <= `FSCD_SR_RST;
      cr_q <= `FSCD_CR_RST;
    end else if (ce && commit) begin
      sr_q <= wbuf_q[`FSCD_RG_SR]; // see R5
      // A one-byte write leaves configuration alone
      if (wcnt_q == `FSCD_WR_MAX) cr_q <= wbuf_q[`FSCD_RG_CR]; // see R5
    end
  end
  sr_write_a: assert property (@(posedge pclk) disable iff (!presetn) // see R5
    ce && commit |=> sr_q[`FSCD_SR_USER] == $past(wbuf_q[`FSCD_SR_USER]) && !wl_q)
    else $error("status write lost");

  // Busy and latch bits are live, not stored
  always_comb begin
    stat               = sr_q;
    stat[`FSCD_SR_WIP] = busy_q;
    stat[`FSCD_SR_WL]  = wl_q;
  end

  // Reload source for repeated read-back bytes
  always_comb begin
    case (src_q)
      fscd_pkg::FSCD_SRC_STAT: rd_val = stat; // see R3
      fscd_pkg::FSCD_SRC_CONF: rd_val = cr_q; // see R4
      default:                 rd_val = 8'h00;
    endcase
  end

  // Read-back: load on opcode, shift out on falling link edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_q   <= fscd_pkg::FSCD_SRC_NONE;
      tx_q    <= 8'h00;
      obit_q  <= 3'h0;
      io_o    <= 4'h0;
      io_oe_n <= `FSCD_OE_OFF;
    end else if (ce) begin
      if (!act) begin
        src_q   <= fscd_pkg::FSCD_SRC_NONE;
        obit_q  <= 3'h0;
        io_oe_n <= `FSCD_OE_OFF;
      end else if (go && op == `FSCD_OP_ST_RD) begin
        src_q <= fscd_pkg::FSCD_SRC_STAT;
        tx_q  <= stat; // see R3
      end else if (go && op == `FSCD_OP_CF_RD) begin
        src_q <= fscd_pkg::FSCD_SRC_CONF;
        tx_q  <= cr_q; // see R4
      end else if (fall && src_q != fscd_pkg::FSCD_SRC_NONE) begin
        // Single lane drives io1 only; four-lane drives all
        io_o    <= four ? tx_q[7:4] : {2'b00, tx_q[7], 1'b0};
        io_oe_n <= four ? `FSCD_OE_FOUR : `FSCD_OE_ONE;
        obit_q  <= (obit_q == last) ? 3'h0 : obit_q + 3'h1;
        // Byte done: repeat with a fresh value until the frame ends
        if (obit_q == last) tx_q <= rd_val;
        else tx_q <= four ? {tx_q[3:0], 4'h0} : {tx_q[6:0], 1'b0};
      end
    end
  end
  st_read_a: assert property (@(posedge pclk) disable iff (!presetn) // see R3
    ce && go && op == `FSCD_OP_ST_RD |=> tx_q == $past(stat) &&
    src_q == fscd_pkg::FSCD_SRC_STAT) else $error("status not loaded");
  cf_read_a: assert property (@(posedge pclk) disable iff (!presetn) // see R4
    ce && go && op == `FSCD_OP_CF_RD |=> tx_q == $past(cr_q) &&
    src_q == fscd_pkg::FSCD_SRC_CONF) else $error("config not loaded");

  // APB: answer is prepared in setup, so pready rises in access
  assign pready = rdy_q & ce;
  assign wr     = psel & penable & rdy_q & pwrite;

  // Register read mux; unmapped addresses flag an error
  always_comb begin
    rd  = 32'h0000_0000;
    err = 1'b0;
    case (paddr)
      `FSCD_A_CTRL: rd[`FSCD_CTRL_BUSY] = busy_q;
      `FSCD_A_STAT: begin
        rd[`FSCD_ST_WL]    = wl_q;
        rd[`FSCD_ST_FOUR]  = four;
        rd[`FSCD_ST_LONG]  = long_q;
        rd[`FSCD_ST_PROT]  = prot_q;
        rd[`FSCD_ST_SUSP]  = susp_q;
        rd[`FSCD_ST_SLEEP] = sleep_q;
      end
      `FSCD_A_REGS: begin
        rd[`FSCD_RG_SR] = stat;
        rd[`FSCD_RG_CR] = cr_q;
      end
      `FSCD_A_LAST: rd[`FSCD_RG_SR] = cmd_q;
      default:      err = 1'b1;
    endcase
  end

  // APB handshake and answer registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdy_q   <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (ce) begin
      if (rdy_q && psel && penable) begin
        rdy_q <= 1'b0;
      end else if (psel && !rdy_q) begin
        rdy_q   <= 1'b1;
        prdata  <= pwrite ? 32'h0000_0000 : rd;
        pslverr <= err;
      end
    end
  end

  // Control register: busy stands in for the array engine
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_q <= 1'b0;
    end else if (ce && wr && paddr == `FSCD_A_CTRL) begin
      busy_q <= pwdata[`FSCD_CTRL_BUSY];
    end
  end

endmodule

/* verilog/fscd_defines.svh */
// Opcodes, register map, field positions and counts of the command decoder
`ifndef FSCD_DEFINES_SVH
`define FSCD_DEFINES_SVH
// Opcodes seen as the first byte of a frame
`define FSCD_OP_WL_SET   8'h06
`define FSCD_OP_WL_CLR   8'h04
`define FSCD_OP_ST_RD    8'h05
`define FSCD_OP_CF_RD    8'h15
`define FSCD_OP_SC_WR    8'h01
`define FSCD_OP_PROT_SEL 8'h68
`define FSCD_OP_FOUR_IN  8'h35
`define FSCD_OP_FOUR_OUT 8'hf5
`define FSCD_OP_LONG_IN  8'hb7
`define FSCD_OP_LONG_OUT 8'he9
`define FSCD_OP_SUSP     8'hb0
`define FSCD_OP_RESUME   8'h30
`define FSCD_OP_WAKE     8'hab
// APB byte offsets
`define FSCD_A_CTRL      12'h000
`define FSCD_A_STAT      12'h004
`define FSCD_A_REGS      12'h008
`define FSCD_A_LAST      12'h00c
// Control register bits
`define FSCD_CTRL_BUSY   0
`define FSCD_CTRL_SLEEP  1
// Mode status register bits
`define FSCD_ST_WL       0
`define FSCD_ST_FOUR     1
`define FSCD_ST_LONG     2
`define FSCD_ST_PROT     3
`define FSCD_ST_SUSP     4
`define FSCD_ST_SLEEP    5
// Flash status byte fields
`define FSCD_SR_WIP      0
`define FSCD_SR_WL       1
`define FSCD_SR_USER     7:2
// Byte lanes of the register view word
`define FSCD_RG_SR       7:0
`define FSCD_RG_CR       15:8
// Reset values
`define FSCD_SR_RST      8'h00
`define FSCD_CR_RST      8'h00
// Last link edge of a byte per lane width
`define FSCD_LAST_ONE    3'h7
`define FSCD_LAST_FOUR   3'h1
// Output enables, low drives
`define FSCD_OE_OFF      4'hf
`define FSCD_OE_ONE      4'hd
`define FSCD_OE_FOUR     4'h0
// Data bytes taken by a status/configuration write
`define FSCD_WR_MAX      2'h2
`endif

/* verilog/fscd_pkg.sv */
// Types shared by the setting-command decoder
package fscd_pkg;
  // Lane width of the command link
  typedef enum logic {FSCD_LANE_ONE, FSCD_LANE_FOUR} fscd_lane_t;
  // Source of read-back data
  typedef enum logic [1:0] {FSCD_SRC_NONE, FSCD_SRC_STAT, FSCD_SRC_CONF} fscd_src_t;
endpackage

/* dv/fscd_host.sv */
// Behavioural serial host that frames commands on the link
`timescale 1ns/100ps
module fscd_host (
  output logic       sclk,
  output logic       cs_n,
  output logic [3:0] io_i,
  input  logic [3:0] io_o,
  input  logic [3:0] io_oe_n
);
  logic [3:0] drv;    // Host lane values
  logic [3:0] drv_en; // Host lane drives
  logic       junk;   // Wander level

  // Link idles with the clock low and the frame closed
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    drv = 4'h0;
    drv_en = 4'h0;
    junk = 1'b0;
  end

  // No pull on the lanes, so a released lane wanders instead of holding
  always #17 junk = ~junk;

  // Lane level from both parties' enables
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      io_i[k] = !io_oe_n[k] ? io_o[k] : (drv_en[k] ? drv[k] : junk);
    end
  end

  // One byte, msb first; data changes while the clock is low
  task automatic put_byte(input logic four, input logic en, input logic [7:0] b,
                          output logic [7:0] got);
    int n;
    n = four ? 2 : 8;
    got = 8'h00;
    for (int k = 0; k < n; k++) begin
      drv_en = en ? (four ? 4'hf : 4'h1) : 4'h0;
      drv = four ? (k == 0 ? b[7:4] : b[3:0]) : {3'h0, b[7-k]};
      #24 sclk = 1'b1;
      got = four ? {got[3:0], io_i} : {got[6:0], io_i[1]};
      #24 sclk = 1'b0;
    end
  endtask

  // Opcode, then up to two data bytes, then read-back bytes
  task automatic frame(input logic four, input logic [7:0] op, input int nwr,
                       input logic [15:0] wd, input int nrd, output logic [7:0] rd);
    logic [7:0] g;
    cs_n = 1'b0;
    #24;
    put_byte(four, 1'b1, op, g);
    for (int i = 0; i < nwr; i++) begin
      put_byte(four, 1'b1, i == 0 ? wd[15:8] : wd[7:0], g);
    end
    rd = 8'h00;
    for (int i = 0; i < nrd; i++) begin
      put_byte(four, 1'b0, 8'h00, rd);
    end
    drv_en = 4'h0;
    #24 cs_n = 1'b1;
    // Gap well above the minimum, lets the decode land first
    #48;
  endtask
endmodule

/* dv/tb_top.sv */
// Self-checking bench for the setting-command decoder
`timescale 1ns/100ps
`include "fscd_defines.svh"
module tb_top;
  logic        pclk;      // System clock
  logic        presetn;   // Reset, low active
  logic        ce;        // Clock enable
  logic        psel;      // APB select
  logic        penable;   // APB access
  logic        pwrite;    // APB direction
  logic [11:0] paddr;     // APB address
  logic [31:0] pwdata;    // APB write data
  logic [31:0] prdata;    // APB read data
  logic        pready;    // APB ready
  logic        pslverr;   // APB error
  logic        sclk;      // Link clock
  logic        cs_n;      // Frame select, low active
  logic [3:0]  io_i;      // Lane levels
  logic [3:0]  io_o;      // Device lane data
  logic [3:0]  io_oe_n;   // Device lane enables, low drives
  logic [7:0]  g;         // Scratch read byte
  int          failures;  // Mismatches
  int          cmp_count; // Comparisons
  int          cyc;       // Cycle count
  localparam logic [31:0] M_WL = 32'h1 << `FSCD_ST_WL;
  localparam logic [31:0] M_FO = 32'h1 << `FSCD_ST_FOUR;
  localparam logic [31:0] M_LG = 32'h1 << `FSCD_ST_LONG;
  localparam logic [31:0] M_PR = 32'h1 << `FSCD_ST_PROT;
  localparam logic [31:0] M_SU = 32'h1 << `FSCD_ST_SUSP;
  localparam logic [31:0] M_SL = 32'h1 << `FSCD_ST_SLEEP;

  fscd_top dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .sclk(sclk), .cs_n(cs_n), .io_i(io_i), .io_o(io_o),
    .io_oe_n(io_oe_n));
  fscd_host host (.sclk(sclk), .cs_n(cs_n), .io_i(io_i), .io_o(io_o), .io_oe_n(io_oe_n));

  // 200 MHz clock
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // Hang guard; the tests need a few thousand cycles
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      failures++;
      summarize();
    end
  end

  task automatic summarize();
    $display("Checks %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input string s, input logic [32:0] seen, input logic [32:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", s, exp, seen);
    end
  endtask

  // One APB transfer; pready, data and error are taken at the completing rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // Values read here are those sampled by this edge
    while (pready !== 1'b1 && n < 100) begin
      @(posedge pclk);
      n++;
    end
    if (n == 100) begin
      failures++;
      summarize();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input string s, input logic [11:0] a, input logic [31:0] x,
                        input logic xe);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(s, {e, r}, {xe, x});
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic mode(input logic [31:0] x);
    rd_chk("mode", `FSCD_A_STAT, x, 1'b0);
  endtask

  task automatic cmd(input logic four, input logic [7:0] op);
    host.frame(four, op, 0, 16'h0, 0, g);
  endtask

  task automatic lrd(input string s, input logic four, input logic [7:0] op,
                     input logic [7:0] x);
    host.frame(four, op, 0, 16'h0, 1, g);
    chk(s, {25'h0, g}, {25'h0, x});
  endtask

  task automatic t_reset();
    mode(32'h0);
    rd_chk("regs", `FSCD_A_REGS, 32'h0, 1'b0);
    rd_chk("unmapped", 12'h010, 32'h0, 1'b1);
  endtask

  task automatic t_latch();
    cmd(1'b0, `FSCD_OP_WL_SET);
    mode(M_WL);
    lrd("status", 1'b0, `FSCD_OP_ST_RD, 8'h1 << `FSCD_SR_WL);
    cmd(1'b0, `FSCD_OP_WL_CLR);
    mode(32'h0);
    rd_chk("last", `FSCD_A_LAST, {24'h0, `FSCD_OP_WL_CLR}, 1'b0);
  endtask

  // Write refused without the latch, then two-byte and one-byte writes
  task automatic t_write();
    host.frame(1'b0, `FSCD_OP_SC_WR, 2, 16'hab5a, 0, g);
    rd_chk("regs", `FSCD_A_REGS, 32'h0, 1'b0);
    cmd(1'b0, `FSCD_OP_WL_SET);
    host.frame(1'b0, `FSCD_OP_SC_WR, 2, 16'hab5a, 0, g);
    rd_chk("regs", `FSCD_A_REGS, 32'h5aa8, 1'b0);
    mode(32'h0);
    cmd(1'b0, `FSCD_OP_WL_SET);
    host.frame(1'b0, `FSCD_OP_SC_WR, 1, 16'h5700, 0, g);
    rd_chk("regs", `FSCD_A_REGS, 32'h5a54, 1'b0);
    lrd("config", 1'b0, `FSCD_OP_CF_RD, 8'h5a);
    lrd("status", 1'b0, `FSCD_OP_ST_RD, 8'h54);
  endtask

  task automatic t_lanes();
    cmd(1'b0, `FSCD_OP_PROT_SEL);
    mode(M_PR);
    cmd(1'b0, `FSCD_OP_LONG_IN);
    mode(M_PR | M_LG);
    cmd(1'b0, `FSCD_OP_LONG_OUT);
    mode(M_PR);
    cmd(1'b0, `FSCD_OP_FOUR_OUT);
    mode(M_PR);
    cmd(1'b0, `FSCD_OP_FOUR_IN);
    mode(M_PR | M_FO);
    cmd(1'b1, `FSCD_OP_FOUR_IN);
    mode(M_PR | M_FO);
    cmd(1'b1, `FSCD_OP_WL_SET);
    mode(M_PR | M_FO | M_WL);
    lrd("status", 1'b1, `FSCD_OP_ST_RD, 8'h56);
    lrd("config", 1'b1, `FSCD_OP_CF_RD, 8'h5a);
    cmd(1'b1, `FSCD_OP_WL_CLR);
    cmd(1'b1, `FSCD_OP_LONG_IN);
    mode(M_PR | M_FO | M_LG);
    cmd(1'b1, `FSCD_OP_LONG_OUT);
    cmd(1'b1, `FSCD_OP_FOUR_OUT);
    mode(M_PR);
  endtask

  task automatic t_susp();
    cmd(1'b0, `FSCD_OP_SUSP);
    mode(M_PR);
    wr(`FSCD_A_CTRL, 32'h1);
    rd_chk("ctrl", `FSCD_A_CTRL, 32'h1, 1'b0);
    cmd(1'b0, `FSCD_OP_SUSP);
    mode(M_PR | M_SU);
    lrd("status", 1'b0, `FSCD_OP_ST_RD, 8'h55);
    cmd(1'b0, `FSCD_OP_RESUME);
    mode(M_PR);
    wr(`FSCD_A_CTRL, 32'h0);
  endtask

  task automatic t_sleep();
    wr(`FSCD_A_CTRL, 32'h2);
    mode(M_PR | M_SL);
    cmd(1'b0, `FSCD_OP_WL_SET);
    mode(M_PR | M_SL);
    cmd(1'b0, `FSCD_OP_WAKE);
    mode(M_PR);
  endtask

  // Enable dropped in the setup phase: ready must wait, answer must survive
  task automatic t_hold();
    fork
      mode(M_PR);
      begin
        @(posedge pclk);
        ce <= 1'b0;
        @(posedge pclk);
        chk("held", {32'h0, pready}, 33'h0);
        ce <= 1'b1;
      end
    join
  endtask

  // Main sequence
  initial begin
    presetn = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    failures = 0;
    cmp_count = 0;
    cyc = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    t_reset();
    t_latch();
    t_write();
    t_lanes();
    t_susp();
    t_sleep();
    t_hold();
    summarize();
  end
endmodule
